// File: logic/drgb_consts.vh
`ifndef DRGB_CONSTS_VH
`define DRGB_CONSTS_VH

// Register offsets on the bus (byte addresses)
`define DRGB_ADR_W 8
`define DRGB_OFS_RGB_EN 8'h00
`define DRGB_OFS_PCLK_CTL 8'h04
`define DRGB_OFS_STATUS 8'h08

// Reset values
`define DRGB_RGB_EN_RST 16'h0000
`define DRGB_PCLK_CTL_RST 2'h0

// Pixel clock pin control fields
`define DRGB_BIT_CLK_EN 0
`define DRGB_BIT_CLK_IO 1
`define DRGB_PCLK_CTL_W 2

// Colour fields, shared by enable register and pixel word
`define DRGB_RED_LO 0
`define DRGB_RED_HI 4
`define DRGB_GRN_LO 5
`define DRGB_GRN_HI 10
`define DRGB_BLU_LO 11
`define DRGB_BLU_HI 15
`define DRGB_PIX_W 16

// Status fields
`define DRGB_STS_EMPTY 0
`define DRGB_STS_FULL 1
`define DRGB_STS_UNDERRUN 2

// Structure and timing defaults
`define DRGB_FIFO_DEPTH 8
`define DRGB_PIX_HALF 2
`define DRGB_PIN_SYNC_W 17

`endif

// File: logic/drgb_fifo.v
module drgb_fifo #(
	parameter W = 16,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	// Clock and reset
	input wire sys_clk_in,
	input wire reset_n_in,
	// Fill side
	input wire in_valid_in,
	output wire in_ready_out,
	input wire [W-1:0] in_data_in,
	// Drain side
	output wire out_valid_out,
	input wire out_ready_in,
	output wire [W-1:0] out_data_out
);

	reg [W-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_ff;
	reg [AW-1:0] rd_ptr_ff;
	reg [AW:0] count_ff;
	wire push;
	wire pop;

	assign in_ready_out = (count_ff != DEPTH[AW:0]);
	assign out_valid_out = (count_ff != {(AW+1){1'b0}});
	assign push = in_valid_in & in_ready_out;
	assign pop = out_valid_out & out_ready_in;
	assign out_data_out = mem[rd_ptr_ff];

	// Storage has no reset; pointers and count do
	always @(posedge sys_clk_in) begin
		if (push) begin
			mem[wr_ptr_ff] <= in_data_in;
		end
	end

	always @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wr_ptr_ff <= {AW{1'b0}};
			rd_ptr_ff <= {AW{1'b0}};
			count_ff <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
			end
			if (push & ~pop) begin
				count_ff <= count_ff + 1'b1;
			end else if (pop & ~push) begin
				count_ff <= count_ff - 1'b1;
			end
		end
	end

endmodule // drgb_fifo

// File: logic/drgb_sync2.v
module drgb_sync2 #(
	parameter W = 1
) (
	// Clock and reset
	input wire sys_clk_in,
	input wire reset_n_in,
	// Levels
	input wire [W-1:0] async_in,
	output wire [W-1:0] sync_out
);

	reg [W-1:0] meta_ff;
	reg [W-1:0] sync_ff;

	always @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			meta_ff <= {W{1'b0}};
			sync_ff <= {W{1'b0}};
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;

endmodule // drgb_sync2

// File: logic/drgb_top.v
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`include "drgb_consts.vh"

module drgb_top #(
	parameter PIX_HALF = `DRGB_PIX_HALF,
	parameter FIFO_DEPTH = `DRGB_FIFO_DEPTH,
	parameter FIFO_AW = 3
) (
	// Clock and reset
	input wire sys_clk_in,
	input wire reset_n_in,
	// Wishbone slave
	input wire wb_cyc_in,
	input wire wb_stb_in,
	input wire wb_we_in,
	input wire [`DRGB_ADR_W-1:0] wb_adr_in,
	input wire [3:0] wb_sel_in,
	input wire [31:0] wb_dat_in,
	output reg [31:0] wb_dat_out,
	output reg wb_ack_out,
	// Pixel stream from display generator
	input wire pix_valid_in,
	output wire pix_ready_out,
	input wire [5:1] pix_red_in,
	input wire [5:0] pix_green_in,
	input wire [5:1] pix_blue_in,
	// Ordinary or alternate function drive of the colour pins
	input wire [15:0] port_out_in,
	input wire [15:0] port_oe_n_in,
	// Ordinary or alternate function drive of the clock pin
	input wire port_clk_out_in,
	input wire port_clk_oe_n_in,
	// Synchronised pin levels for the port functions, clock pin on top
	output wire [16:0] port_pin_sync_out,
	// Colour pins
	input wire [15:0] rgb_pin_in,
	output reg [15:0] rgb_pin_out,
	output reg [15:0] rgb_pin_oe_n_out,
	// Pixel clock pin
	input wire clk_pin_in,
	output reg clk_pin_out,
	output reg clk_pin_oe_n_out
);

	// Registers
	reg [15:0] rgb_pin_enable_ff;
	reg [`DRGB_PCLK_CTL_W-1:0] pclk_ctl_ff;
	reg underrun_ff;
	reg [15:0] nxt_rgb_pin_enable;
	reg [`DRGB_PCLK_CTL_W-1:0] nxt_pclk_ctl;
	reg nxt_underrun;

	// Pixel clock generation and capture
	reg [7:0] div_cnt_ff;
	reg pixel_clock_out_ff;
	reg ext_clk_prev_ff;
	reg [15:0] pixel_ff;

	wire [16:0] pin_sync;
	wire pixel_clock_in;
	wire clk_pin_on;
	wire clk_pin_input;
	wire div_tick;
	wire int_fall;
	wire ext_rise;
	wire drain_evt;
	wire fifo_valid;
	wire fifo_ready;
	wire [15:0] fifo_word;
	wire [15:0] pix_word;
	wire bus_req;
	wire bus_wr;
	wire sts_empty;
	wire sts_full;

	assign clk_pin_on = pclk_ctl_ff[`DRGB_BIT_CLK_EN];
	assign clk_pin_input = clk_pin_on & pclk_ctl_ff[`DRGB_BIT_CLK_IO];

	// Only red and blue bits 1-5 and green bits 0-5 enter the word
	assign pix_word[`DRGB_RED_HI:`DRGB_RED_LO] = pix_red_in;
	assign pix_word[`DRGB_GRN_HI:`DRGB_GRN_LO] = pix_green_in;
	assign pix_word[`DRGB_BLU_HI:`DRGB_BLU_LO] = pix_blue_in;

	drgb_fifo #(
		.W(`DRGB_PIX_W),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.sys_clk_in(sys_clk_in),
		.reset_n_in(reset_n_in),
		.in_valid_in(pix_valid_in),
		.in_ready_out(pix_ready_out),
		.in_data_in(pix_word),
		.out_valid_out(fifo_valid),
		.out_ready_in(fifo_ready),
		.out_data_out(fifo_word)
	);

	drgb_sync2 #(
		.W(`DRGB_PIN_SYNC_W)
	) u_pin_sync (
		.sys_clk_in(sys_clk_in),
		.reset_n_in(reset_n_in),
		.async_in({clk_pin_in, rgb_pin_in}),
		.sync_out(pin_sync)
	);

	assign port_pin_sync_out = pin_sync;
	assign pixel_clock_in = pin_sync[16];

	// Internal pixel clock: divider tick toggles the output level
	assign div_tick = (div_cnt_ff == PIX_HALF[7:0] - 8'h01);
	assign int_fall = div_tick & pixel_clock_out_ff;
	assign ext_rise = pixel_clock_in & ~ext_clk_prev_ff;

	// Internal clock: new pixel on falling edge, stable at rising edge
	assign drain_evt = clk_pin_input ? ext_rise : int_fall;
	assign fifo_ready = drain_evt;

	always @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			div_cnt_ff <= 8'h00;
			pixel_clock_out_ff <= 1'b0;
			ext_clk_prev_ff <= 1'b0;
			pixel_ff <= 16'h0000;
		end else begin
			div_cnt_ff <= div_tick ? 8'h00 : div_cnt_ff + 8'h01;
			if (div_tick) begin
				pixel_clock_out_ff <= ~pixel_clock_out_ff;
			end
			ext_clk_prev_ff <= pixel_clock_in;
			// On underrun the last pixel is held
			if (drain_evt & fifo_valid) begin
				pixel_ff <= fifo_word;
			end
		end
	end

	// Pin muxing, registered so pins do not glitch on enable changes
	always @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rgb_pin_out <= 16'h0000;
			rgb_pin_oe_n_out <= 16'hFFFF;
			clk_pin_out <= 1'b0;
			clk_pin_oe_n_out <= 1'b1;
		end else begin
			rgb_pin_out <= (rgb_pin_enable_ff & pixel_ff)
				| (~rgb_pin_enable_ff & port_out_in);
			rgb_pin_oe_n_out <= ~rgb_pin_enable_ff & port_oe_n_in;
			if (!clk_pin_on) begin
				clk_pin_out <= port_clk_out_in;
				clk_pin_oe_n_out <= port_clk_oe_n_in;
			end else if (clk_pin_input) begin
				clk_pin_out <= 1'b0;
				clk_pin_oe_n_out <= 1'b1;
			end else begin
				clk_pin_out <= pixel_clock_out_ff;
				clk_pin_oe_n_out <= 1'b0;
			end
		end
	end

	// Wishbone classic slave, one registered answer per request, acknowledged one cycle later
	assign bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
	assign bus_wr = bus_req & wb_we_in;
	assign sts_empty = ~fifo_valid;
	assign sts_full = ~pix_ready_out;

	always @* begin
		nxt_rgb_pin_enable = rgb_pin_enable_ff;
		nxt_pclk_ctl = pclk_ctl_ff;
		nxt_underrun = underrun_ff;
		if (bus_wr && wb_adr_in == `DRGB_OFS_RGB_EN) begin
			if (wb_sel_in[0]) begin
				nxt_rgb_pin_enable[7:0] = wb_dat_in[7:0];
			end
			if (wb_sel_in[1]) begin
				nxt_rgb_pin_enable[15:8] = wb_dat_in[15:8];
			end
		end
		if (bus_wr && wb_adr_in == `DRGB_OFS_PCLK_CTL && wb_sel_in[0]) begin
			nxt_pclk_ctl = wb_dat_in[`DRGB_PCLK_CTL_W-1:0];
		end
		if (bus_wr && wb_adr_in == `DRGB_OFS_STATUS && wb_sel_in[0]
			&& wb_dat_in[`DRGB_STS_UNDERRUN]) begin
			nxt_underrun = 1'b0;
		end
		// A new underrun wins over a clear in the same cycle
		if (drain_evt & ~fifo_valid) begin
			nxt_underrun = 1'b1;
		end
	end

	always @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rgb_pin_enable_ff <= `DRGB_RGB_EN_RST;
			pclk_ctl_ff <= `DRGB_PCLK_CTL_RST;
			underrun_ff <= 1'b0;
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h00000000;
		end else begin
			rgb_pin_enable_ff <= nxt_rgb_pin_enable;
			pclk_ctl_ff <= nxt_pclk_ctl;
			underrun_ff <= nxt_underrun;
			wb_ack_out <= bus_req;
			wb_dat_out <= 32'h00000000;
			if (bus_req && !wb_we_in) begin
				case (wb_adr_in)
					`DRGB_OFS_RGB_EN: begin
						wb_dat_out[15:0] <= rgb_pin_enable_ff;
					end
					`DRGB_OFS_PCLK_CTL: begin
						wb_dat_out[`DRGB_PCLK_CTL_W-1:0] <= pclk_ctl_ff;
					end
					`DRGB_OFS_STATUS: begin
						wb_dat_out[`DRGB_STS_EMPTY] <= sts_empty;
						wb_dat_out[`DRGB_STS_FULL] <= sts_full;
						wb_dat_out[`DRGB_STS_UNDERRUN] <= underrun_ff;
					end
					default: begin
						wb_dat_out <= 32'h00000000;
					end
				endcase
			end
		end
	end

endmodule // drgb_top

// File: sim/drgb_checker.sv
module drgb_checker (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	// Register bus
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_ack_out,
	input wire logic [31:0] wb_dat_out,
	// Pins
	input wire logic [15:0] port_oe_n_in,
	input wire logic port_clk_oe_n_in,
	input wire logic [15:0] rgb_pin_in,
	input wire logic [15:0] rgb_pin_oe_n_out,
	input wire logic clk_pin_in,
	input wire logic clk_pin_out,
	input wire logic clk_pin_oe_n_out,
	input wire logic [16:0] port_pin_sync_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!reset_n_in);
	property p_ack_one; wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out; endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack late");
	property p_ack_pulse; wb_ack_out |=> !wb_ack_out; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_ack_req; !(wb_cyc_in && wb_stb_in) |=> !wb_ack_out; endproperty
	a_ack_req: assert property (p_ack_req) else $error("ack without request");
	property p_dat_idle; !wb_ack_out |-> wb_dat_out == 32'h0; endproperty
	a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
	// A pin left undriven by the block may only be one the port function left undriven
	property p_oe_pass;
		$past(reset_n_in) |-> (rgb_pin_oe_n_out & ~$past(port_oe_n_in)) == 16'h0;
	endproperty
	a_oe_pass: assert property (p_oe_pass) else $error("colour pin enable");
	property p_clk_in;
		$past(reset_n_in) && clk_pin_oe_n_out && !$past(port_clk_oe_n_in) |-> !clk_pin_out;
	endproperty
	a_clk_in: assert property (p_clk_in) else $error("clock input mode");
	property p_sync_rgb; $past(reset_n_in, 2) |-> port_pin_sync_out[15:0] == $past(rgb_pin_in, 2);
	endproperty
	a_sync_rgb: assert property (p_sync_rgb) else $error("colour pin sync");
	property p_sync_clk; $past(reset_n_in, 2) |-> port_pin_sync_out[16] == $past(clk_pin_in, 2);
	endproperty
	a_sync_clk: assert property (p_sync_clk) else $error("clock pin sync");
	c_ack: cover property (wb_ack_out);
	c_clk_in: cover property (clk_pin_oe_n_out && !port_clk_oe_n_in);
	c_ext_edge: cover property ($rose(port_pin_sync_out[16]));
endmodule // drgb_checker

// File: sim/drgb_display.sv
module drgb_display (
	// Frame control
	input wire logic run_in,
	// Pins
	input wire logic [15:0] pin_in,
	output logic clk_out,
	output logic drive_out,
	output logic [15:0] pix_out,
	output logic [7:0] count_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// Clock stands still between frames; offset keeps it off system clock edges
	initial begin
		{clk_out, drive_out, pix_out, count_out} = '0;
		forever begin
			@(posedge run_in);
			#3 drive_out = 1'b1;
			while (run_in) begin
				#80 clk_out = 1'b1;
				#80 clk_out = 1'b0;
				pix_out = pin_in;
				count_out++;
			end
			drive_out = 1'b0;
		end
	end
endmodule // drgb_display

// File: sim/drgb_top_tb.sv
`include "drgb_consts.vh"
module drgb_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_in, reset_n_in, wb_cyc_in, wb_stb_in, wb_we_in, pix_valid_in, run, c;
	logic port_clk_out_in, port_clk_oe_n_in;
	logic [7:0] wb_adr_in;
	logic [3:0] wb_sel_in;
	logic [31:0] wb_dat_in, q;
	logic [5:1] pix_red_in, pix_blue_in;
	logic [5:0] pix_green_in;
	logic [15:0] port_out_in, port_oe_n_in;
	wire [31:0] wb_dat_out;
	wire wb_ack_out, pix_ready_out, clk_pin_out, clk_pin_oe_n_out, ext_clk, ext_drv;
	wire [16:0] port_pin_sync_out;
	wire [15:0] rgb_pin_out, rgb_pin_oe_n_out, seen;
	wire [7:0] n_seen;
	int num_errors = 0, n_compared = 0, i, k;
	// Released pins float high
	wire [15:0] rgb_pin_in = rgb_pin_oe_n_out | rgb_pin_out;
	wire clk_pin_in = clk_pin_oe_n_out ? (ext_drv ? ext_clk : 1'b1) : clk_pin_out;
	drgb_top drgb_top_inst (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
		.wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
		.wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
		.wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
		.pix_valid_in(pix_valid_in), .pix_ready_out(pix_ready_out),
		.pix_red_in(pix_red_in), .pix_green_in(pix_green_in), .pix_blue_in(pix_blue_in),
		.port_out_in(port_out_in), .port_oe_n_in(port_oe_n_in),
		.port_clk_out_in(port_clk_out_in), .port_clk_oe_n_in(port_clk_oe_n_in),
		.port_pin_sync_out(port_pin_sync_out),
		.rgb_pin_in(rgb_pin_in), .rgb_pin_out(rgb_pin_out), .rgb_pin_oe_n_out(rgb_pin_oe_n_out),
		.clk_pin_in(clk_pin_in), .clk_pin_out(clk_pin_out), .clk_pin_oe_n_out(clk_pin_oe_n_out));
	drgb_display drgb_display_inst (.run_in(run), .pin_in(rgb_pin_in), .clk_out(ext_clk),
		.drive_out(ext_drv), .pix_out(seen), .count_out(n_seen));
	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
		n_compared++;
		if (s !== e) begin
			$display("wrong value %s exp %h seen %h", nm, e, s);
			num_errors++;
		end
	endtask
	task automatic conclude;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		{wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in} <= {2'b11, w, a, d};
		k = 0;
		do begin
			@(posedge sys_clk_in);
			k++;
		end while (wb_ack_out !== 1'b1 && k < 50);
		if (k == 50) begin
			num_errors++;
			conclude;
		end
		q = wb_dat_out;
		{wb_cyc_in, wb_stb_in} <= 2'b00;
		@(posedge sys_clk_in);
	endtask
	initial begin
		sys_clk_in = 0;
		forever #5 sys_clk_in = ~sys_clk_in;
	end
	initial begin
		{reset_n_in, wb_cyc_in, wb_stb_in, wb_we_in, pix_valid_in, run} = '0;
		{wb_adr_in, wb_dat_in, pix_red_in, pix_green_in, pix_blue_in} = '0;
		{wb_sel_in, port_oe_n_in, port_out_in} = {4'hF, 16'hA5A5, 16'h3C3C};
		{port_clk_out_in, port_clk_oe_n_in} = 2'b01;
		repeat (10) @(posedge sys_clk_in);
		reset_n_in <= 1'b1;
		@(posedge sys_clk_in);
		bus(0, `DRGB_OFS_RGB_EN, 0);
		chk(q, 0, "rgb_en");
		chk({rgb_pin_oe_n_out, rgb_pin_out}, 32'hA5A53C3C, "pins");
		bus(1, `DRGB_OFS_PCLK_CTL, 32'hFFFFFFFF);
		bus(0, `DRGB_OFS_PCLK_CTL, 0);
		chk(q, 32'h3, "pclk_ctl");
		chk({clk_pin_oe_n_out, clk_pin_out}, 2'b10, "clk in");
		bus(0, 8'h0C, 0);
		chk(q, 0, "unmapped");
		{port_clk_out_in, port_clk_oe_n_in} <= 2'b10;
		bus(1, `DRGB_OFS_PCLK_CTL, 32'h2);
		bus(0, 8'h0C, 0);
		chk({clk_pin_oe_n_out, clk_pin_out}, 2'b01, "clk off");
		bus(1, `DRGB_OFS_PCLK_CTL, 32'h1);
		repeat (2) @(posedge sys_clk_in);
		c = clk_pin_out;
		repeat (`DRGB_PIX_HALF) @(posedge sys_clk_in);
		chk({clk_pin_oe_n_out, clk_pin_out}, {1'b0, ~c}, "clk out");
		repeat (`DRGB_PIX_HALF) @(posedge sys_clk_in);
		chk({clk_pin_oe_n_out, clk_pin_out}, {1'b0, c}, "clk out period");
		bus(1, `DRGB_OFS_RGB_EN, 32'h001F);
		bus(1, `DRGB_OFS_PCLK_CTL, 32'h3);
		chk(rgb_pin_oe_n_out, 16'hA5A0, "red only");
		// No pixel pushed yet, so enabled red pins carry zero
		chk(rgb_pin_out, 16'h3C20, "red only out");
		bus(1, `DRGB_OFS_RGB_EN, 32'hFFFF);
		for (i = 0; i < 8; i++) begin
			chk(pix_ready_out, 1'b1, "ready");
			pix_valid_in <= 1'b1;
			{pix_blue_in, pix_green_in, pix_red_in} <= 16'(16'h1357 * (i + 1));
			@(posedge sys_clk_in);
		end
		pix_valid_in <= 1'b0;
		@(posedge sys_clk_in);
		chk(pix_ready_out, 1'b0, "full");
		// Internal clock drained an empty FIFO earlier, so underrun is sticky
		bus(0, `DRGB_OFS_STATUS, 0);
		chk(q, 32'h6, "status full underrun");
		bus(1, `DRGB_OFS_STATUS, 32'h4);
		bus(0, `DRGB_OFS_STATUS, 0);
		chk(q, 32'h2, "status cleared");
		run <= 1'b1;
		for (i = 0; i < 8; i++) begin
			for (k = 0; n_seen != 8'(i + 1) && k < 100; k++) @(posedge sys_clk_in);
			if (k == 100) begin
				num_errors++;
				conclude;
			end
			chk(seen, 16'(16'h1357 * (i + 1)), "pixel");
		end
		// Read before the next external rising edge can flag an underrun
		bus(0, `DRGB_OFS_STATUS, 0);
		chk(q, 32'h1, "status empty");
		run <= 1'b0;
		conclude;
	end
endmodule // drgb_top_tb
bind drgb_top drgb_checker drgb_checker_inst (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
	.wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out),
	.wb_dat_out(wb_dat_out), .port_oe_n_in(port_oe_n_in), .port_clk_oe_n_in(port_clk_oe_n_in),
	.rgb_pin_in(rgb_pin_in), .rgb_pin_oe_n_out(rgb_pin_oe_n_out), .clk_pin_in(clk_pin_in),
	.clk_pin_out(clk_pin_out), .clk_pin_oe_n_out(clk_pin_oe_n_out),
	.port_pin_sync_out(port_pin_sync_out));
